// ---- include/interval_timer_consts.svh ----
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH

// ==========================================================
// timebase
`define BUS_CLK_HZ       64'd4915200
`define PRESCALE_SLOW    64'd8
`define PRESCALE_WIDTH   12
`define FAST_TAP_BIT     0
`define SLOW_TAP_LOW     3'h3
`define SLOW_TAP_BITS    2:0
`define TICK_PERIOD_MS   64'd20
`define MS_PER_S         64'd1000
`define TIMEOUT_PERIODS  8
`define TICK_RELOAD      16'((`BUS_CLK_HZ / `PRESCALE_SLOW) * `TICK_PERIOD_MS / `MS_PER_S)

// ==========================================================
// access decode
`define ADDR_CTRL        2'h3
`define SEL_NONE         2'h3
`define CW_SEL           7:6
`define CW_RW            5:4
`define CW_MODE          3:1
`define NUM_COUNTERS     3
`define CNT_TICK         0
`define CNT_TIMER        1
`define CNT_BAUD         2
`define COUNT_ONE        16'h0001

`endif

// ---- include/interval_timer_pkg.sv ----
package interval_timer_pkg;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    RW_LATCH = 2'b00,
    RW_LSB   = 2'b01,
    RW_MSB   = 2'b10,
    RW_BOTH  = 2'b11
  } rw_mode_e;

  typedef enum logic [2:0] {
    MODE_TERM     = 3'b000,
    MODE_ONESHOT  = 3'b001,
    MODE_RATE     = 3'b010,
    MODE_SQUARE   = 3'b011,
    MODE_SWSTROBE = 3'b100,
    MODE_HWSTROBE = 3'b101,
    MODE_RATE_X   = 3'b110,
    MODE_SQUARE_X = 3'b111
  } count_mode_e;

  // ==========================================================
  // module state
  typedef struct packed {
    logic [11:0] count;
    logic        fastTick;
    logic        slowTick;
  } prescale_state_s;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic        armed;
    logic        outLevel;
  } counter_state_s;

  typedef struct packed {
    logic [1:0]             bb;
    logic [1:0]             rst;
    logic [1:0]             decA;
    logic [1:0]             decB;
    logic [1:0]             rd;
    logic [1:0]             wr;
    logic [1:0]             a1;
    logic [1:0]             a2;
    logic [1:0][7:0]        data;
    logic                   bbPrev;
    logic                   rdPrev;
    logic                   wrPrev;
    logic                   wrCs;
    logic [1:0]             wrAddr;
    logic [7:0]             wrData;
    logic                   rdCs;
    logic [1:0]             rdAddr;
    rw_mode_e [2:0]         rwMode;
    count_mode_e [2:0]      mode;
    logic [2:0]             writeHigh;
    logic [2:0]             readHigh;
    logic [2:0]             latched;
    logic [2:0][15:0]       latchVal;
    logic [2:0][7:0]        loadLow;
    logic [2:0]             loadPulse;
    logic [15:0]            loadValue;
    logic [7:0]             dataOut;
    logic                   dataOe_n;
    logic                   tickOut;
    logic                   timerOut;
    logic                   baudOut;
  } unit_state_s;

endpackage

// ---- rtl/timer_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module timer_prescaler
  import interval_timer_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // bus clock edge and local clear
  input  wire logic busClkRise,
  input  wire logic clear,
  // derived clock edges, one-cycle pulses
  output logic      fastTick,
  output logic      slowTick
);

  prescale_state_s r;
  prescale_state_s n;

  // ==========================================================
  // binary prescaler
  always_comb begin
    n = r;
    n.fastTick = 1'b0;
    n.slowTick = 1'b0;
    if (clear) begin
      n.count = '0;
    end else if (busClkRise) begin
      n.count = r.count + 12'h001;
      // rising edges of the divide-by-two and divide-by-eight taps
      n.fastTick = ~r.count[`FAST_TAP_BIT];
      n.slowTick = (r.count[`SLOW_TAP_BITS] == `SLOW_TAP_LOW);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign fastTick = r.fastTick;
  assign slowTick = r.slowTick;

endmodule

`default_nettype wire

// ---- rtl/down_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module down_counter
  import interval_timer_pkg::*;
#(
  parameter logic [15:0] RESET_LOAD  = 16'h0000,
  parameter logic        RESET_ARMED = 1'b0
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // count control
  input  wire logic        tickEn,
  input  wire logic        loadPulse,
  input  wire logic [15:0] loadValue,
  input  wire count_mode_e mode,
  // state
  output logic [15:0]      count,
  output logic             outLevel
);

  counter_state_s r;
  counter_state_s n;

  // ==========================================================
  // down count
  // gate inputs are tied active, so no gate term appears here
  always_comb begin
    n = r;
    if (loadPulse) begin
      n.count    = loadValue;
      n.reload   = loadValue;
      n.armed    = 1'b1;
      n.outLevel = 1'b0;
    end else if (tickEn && r.armed) begin
      n.count = r.count - `COUNT_ONE;
      case (mode)
        MODE_RATE, MODE_RATE_X: begin
          // one tick high as the count reaches zero
          n.outLevel = (r.count == `COUNT_ONE);
          if (r.count == `COUNT_ONE) begin
            n.count = r.reload;
          end
        end
        MODE_SQUARE, MODE_SQUARE_X: begin
          if (r.count == `COUNT_ONE) begin
            n.count    = r.reload;
            n.outLevel = 1'b1;
          end else if (n.count == {1'b0, r.reload[15:1]}) begin
            n.outLevel = 1'b0;
          end
        end
        default: begin
          // terminal count: high at zero and held, count wraps on
          if (r.count == `COUNT_ONE) begin
            n.outLevel = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r.count    <= RESET_LOAD;
      r.reload   <= RESET_LOAD;
      r.armed    <= RESET_ARMED;
      r.outLevel <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign count    = r.count;
  assign outLevel = r.outLevel;

endmodule

`default_nettype wire

// ---- rtl/interval_timer_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"

module interval_timer_unit
  import interval_timer_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // timebase pins
  input  wire logic       bufferedBusClock,
  input  wire logic       localReset,
  // processor bus pins
  input  wire logic       timerDecodeA_n,
  input  wire logic       timerDecodeB_n,
  input  wire logic       addrBitOne,
  input  wire logic       addrBitTwo,
  input  wire logic       readStrobe_n,
  input  wire logic       advancedWriteStrobe_n,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe_n,
  // counter outputs
  output logic            counter0TickOut,
  output logic            counter1TimerOut,
  output logic            transmitBaudClock
);

  unit_state_s       r;
  unit_state_s       n;
  logic              fastTick;
  logic              slowTick;
  logic [2:0]        cntTick;
  logic [2:0][15:0]  cntCount;
  logic [2:0]        cntOut;
  logic              cs;
  logic              rdAct;
  logic              wrAct;
  logic [1:0]        addr;
  logic [1:0]        rdSel;
  logic [15:0]       rdVal;
  logic [1:0]        wSel;
  logic [1:0]        cwSel;
  rw_mode_e          cwRw;

  // ==========================================================
  // prescaler
  timer_prescaler u_prescaler (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .busClkRise (r.bb[1] & ~r.bbPrev),
    .clear      (r.rst[1]),
    .fastTick   (fastTick),
    .slowTick   (slowTick)
  );

  assign cntTick[`CNT_TICK]  = slowTick;
  assign cntTick[`CNT_TIMER] = slowTick;
  assign cntTick[`CNT_BAUD]  = fastTick;

  // ==========================================================
  // counters
  // counter 0 comes out of reset already running the 20 ms tick, so the
  // bus-timeout detector has a clock even before firmware starts
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_COUNTERS; gi = gi + 1) begin : g_cnt
      down_counter #(
        .RESET_LOAD  ((gi == `CNT_TICK) ? `TICK_RELOAD : 16'h0000),
        .RESET_ARMED (gi == `CNT_TICK)
      ) u_cnt (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .tickEn    (cntTick[gi]),
        .loadPulse (r.loadPulse[gi]),
        .loadValue (r.loadValue),
        .mode      (r.mode[gi]),
        .count     (cntCount[gi]),
        .outLevel  (cntOut[gi])
      );
    end
  endgenerate

  // ==========================================================
  // synchronised pin view
  assign cs    = ~r.decA[1] | ~r.decB[1];
  assign rdAct = ~r.rd[1];
  assign wrAct = ~r.wr[1];
  assign addr  = {r.a2[1], r.a1[1]};

  // ==========================================================
  // read data path
  always_comb begin
    rdSel = (addr == `ADDR_CTRL) ? 2'h0 : addr;
    // a latched snapshot wins, otherwise the live count is shown
    rdVal = r.latched[rdSel] ? r.latchVal[rdSel] : cntCount[rdSel];
  end

  // ==========================================================
  // control word fields of the byte being committed
  always_comb begin
    wSel  = (r.wrAddr == `ADDR_CTRL) ? 2'h0 : r.wrAddr;
    cwSel = r.wrData[`CW_SEL];
    cwRw  = rw_mode_e'(r.wrData[`CW_RW]);
  end

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    // first stage feeds only the second stage
    n.bb   = {r.bb[0], bufferedBusClock};
    n.rst  = {r.rst[0], localReset};
    n.decA = {r.decA[0], timerDecodeA_n};
    n.decB = {r.decB[0], timerDecodeB_n};
    n.rd   = {r.rd[0], readStrobe_n};
    n.wr   = {r.wr[0], advancedWriteStrobe_n};
    n.a1   = {r.a1[0], addrBitOne};
    n.a2   = {r.a2[0], addrBitTwo};
    n.data = {r.data[0], dataIn};
    n.bbPrev = r.bb[1];
    n.rdPrev = rdAct;
    n.wrPrev = wrAct;
    n.loadPulse = 3'b000;

    // hold the access context while the strobe is active; commit it on
    // the trailing edge, when address and data have settled
    if (wrAct) begin
      n.wrCs   = cs;
      n.wrAddr = addr;
      n.wrData = r.data[1];
    end
    if (rdAct) begin
      n.rdCs   = cs;
      n.rdAddr = addr;
    end

    // read drive: only while selected and aimed at a counter
    n.dataOe_n = 1'b1;
    n.dataOut  = 8'h00;
    if (rdAct && cs && addr != `ADDR_CTRL) begin
      n.dataOe_n = 1'b0;
      case (r.rwMode[rdSel])
        RW_MSB:  n.dataOut = rdVal[15:8];
        RW_BOTH: n.dataOut = r.readHigh[rdSel] ? rdVal[15:8] : rdVal[7:0];
        default: n.dataOut = rdVal[7:0];
      endcase
    end

    // write commit; an unselected strobe is ignored
    if (r.wrPrev && !wrAct && r.wrCs) begin
      if (r.wrAddr == `ADDR_CTRL) begin
        if (cwSel != `SEL_NONE) begin
          if (cwRw == RW_LATCH) begin
            // snapshot lets a two-byte read see one consistent value
            n.latched[cwSel]  = 1'b1;
            n.latchVal[cwSel] = cntCount[cwSel];
            n.readHigh[cwSel] = 1'b0;
          end else begin
            n.rwMode[cwSel]    = cwRw;
            n.mode[cwSel]      = count_mode_e'(r.wrData[`CW_MODE]);
            n.writeHigh[cwSel] = 1'b0;
            n.readHigh[cwSel]  = 1'b0;
            n.latched[cwSel]   = 1'b0;
          end
        end
      end else begin
        case (r.rwMode[wSel])
          RW_LSB: begin
            n.loadValue       = {8'h00, r.wrData};
            n.loadPulse[wSel] = 1'b1;
          end
          RW_MSB: begin
            n.loadValue       = {r.wrData, 8'h00};
            n.loadPulse[wSel] = 1'b1;
          end
          RW_BOTH: begin
            if (!r.writeHigh[wSel]) begin
              n.loadLow[wSel]   = r.wrData;
              n.writeHigh[wSel] = 1'b1;
            end else begin
              n.loadValue       = {r.wrData, r.loadLow[wSel]};
              n.loadPulse[wSel] = 1'b1;
              n.writeHigh[wSel] = 1'b0;
            end
          end
          default: begin
            // never-programmed counter 1 or 2 takes no count byte
          end
        endcase
      end
    end

    // read commit: step the byte order, release a consumed snapshot
    if (r.rdPrev && !rdAct && r.rdCs && r.rdAddr != `ADDR_CTRL) begin
      if (r.rwMode[r.rdAddr] == RW_BOTH) begin
        n.readHigh[r.rdAddr] = ~r.readHigh[r.rdAddr];
        if (r.readHigh[r.rdAddr]) begin
          n.latched[r.rdAddr] = 1'b0;
        end
      end else begin
        n.latched[r.rdAddr] = 1'b0;
      end
    end

    // counter outputs
    n.tickOut  = cntOut[`CNT_TICK];
    n.timerOut = cntOut[`CNT_TIMER];
    n.baudOut  = ~cntOut[`CNT_BAUD];
  end

  // ==========================================================
  // state register
  // counters 1 and 2 stay idle until programmed; that is one of the
  // states software must already tolerate before initialisation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.rd <= 2'b11;
      r.wr <= 2'b11;
      r.decA <= 2'b11;
      r.decB <= 2'b11;
      r.dataOe_n <= 1'b1;
      r.baudOut <= 1'b1;
      r.rwMode[`CNT_TICK] <= RW_BOTH;
      r.mode[`CNT_TICK] <= MODE_SQUARE;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign dataOut           = r.dataOut;
  assign dataOe_n          = r.dataOe_n;
  assign counter0TickOut   = r.tickOut;
  assign counter1TimerOut  = r.timerOut;
  assign transmitBaudClock = r.baudOut;

endmodule

`default_nettype wire

// ---- test/interval_timer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module interval_timer_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins watched
  input wire logic localReset,
  input wire logic timerDecodeA_n,
  input wire logic timerDecodeB_n,
  input wire logic addrBitOne,
  input wire logic addrBitTwo,
  input wire logic readStrobe_n,
  input wire logic advancedWriteStrobe_n,
  input wire logic dataOe_n,
  input wire logic counter0TickOut,
  input wire logic counter1TimerOut,
  input wire logic transmitBaudClock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic sel;
  logic ctl;
  assign sel = !(timerDecodeA_n && timerDecodeB_n);
  assign ctl = addrBitOne && addrBitTwo;

  // ==========================================================
  // read cycle pieces
  sequence rd_start;
    $fell(readStrobe_n) && sel && !ctl;
  endsequence
  sequence rd_held;
    (!readStrobe_n && sel && !ctl)[*6];
  endsequence

  // ==========================================================
  // checks
  a_reset_quiet: assert property ($fell(sys_rst) |-> dataOe_n &&
    !counter0TickOut && !counter1TimerOut && transmitBaudClock)
    else $error("outputs not idle after reset");
  a_read_drive: assert property (rd_held |-> !dataOe_n)
    else $error("counter read not driven");
  a_oe_timing: assert property (rd_start |-> ##[1:5] !dataOe_n)
    else $error("read answer late");
  a_oe_release: assert property (readStrobe_n[*6] |-> dataOe_n)
    else $error("bus driven without read strobe");
  a_noselect_quiet: assert property ((!sel)[*6] |-> dataOe_n)
    else $error("bus driven without select");
  a_ctrl_no_drive: assert property (ctl[*6] |-> dataOe_n)
    else $error("control word place driven");
  a_write_no_drive: assert property
    ((!advancedWriteStrobe_n)[*4] |-> dataOe_n)
    else $error("bus driven during write");
  a_lreset_freeze: assert property (localReset[*8] |->
    $stable(counter0TickOut) && $stable(transmitBaudClock))
    else $error("counting while prescaler cleared");
endmodule

bind interval_timer_unit interval_timer_monitor interval_timer_monitor_inst (
  .clk                   (clk),
  .sys_rst               (sys_rst),
  .localReset            (localReset),
  .timerDecodeA_n        (timerDecodeA_n),
  .timerDecodeB_n        (timerDecodeB_n),
  .addrBitOne            (addrBitOne),
  .addrBitTwo            (addrBitTwo),
  .readStrobe_n          (readStrobe_n),
  .advancedWriteStrobe_n (advancedWriteStrobe_n),
  .dataOe_n              (dataOe_n),
  .counter0TickOut       (counter0TickOut),
  .counter1TimerOut      (counter1TimerOut),
  .transmitBaudClock     (transmitBaudClock)
);

`default_nettype wire

// ---- test/cpu_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
  // clock
  input  wire logic       clk,
  // answer from the timer
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe_n,
  // processor bus
  output logic            timerDecodeA_n,
  output logic            timerDecodeB_n,
  output logic            addrBitOne,
  output logic            addrBitTwo,
  output logic            readStrobe_n,
  output logic            advancedWriteStrobe_n,
  output logic      [7:0] dataIn
);
  initial begin
    timerDecodeA_n = 1'b1;
    timerDecodeB_n = 1'b1;
    addrBitOne = 1'b0;
    addrBitTwo = 1'b0;
    readStrobe_n = 1'b1;
    advancedWriteStrobe_n = 1'b1;
    dataIn = 8'h00;
  end

  // s: 0 decode a, 1 decode b, 2 none; strobe held 6 clk, gap at least 7 clk
  task automatic drive(input logic [1:0] s, input logic [1:0] a,
                       input logic [7:0] d, input logic isRd);
    @(posedge clk);
    timerDecodeA_n <= (s != 2'h0);
    timerDecodeB_n <= (s != 2'h1);
    {addrBitTwo, addrBitOne} <= a;
    dataIn <= d;
    readStrobe_n <= !isRd;
    advancedWriteStrobe_n <= isRd;
    repeat (6) @(posedge clk);
  endtask

  // a released data line shows the inverse, not the old byte
  task automatic idle(input logic [7:0] d);
    readStrobe_n <= 1'b1;
    advancedWriteStrobe_n <= 1'b1;
    timerDecodeA_n <= 1'b1;
    timerDecodeB_n <= 1'b1;
    dataIn <= ~d;
    repeat (6) @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] s, input logic [1:0] a,
                    input logic [7:0] d);
    drive(s, a, d, 1'b0);
    idle(d);
  endtask

  task automatic rd(input logic [1:0] s, input logic [1:0] a,
                    output logic [7:0] d, output logic oe);
    drive(s, a, ~dataIn, 1'b1);
    d = dataOut;
    oe = dataOe_n;
    idle(dataIn);
  endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk;
  logic       sys_rst;
  logic       bufferedBusClock;
  logic       localReset;
  logic       decA_n;
  logic       decB_n;
  logic       a1;
  logic       a2;
  logic       rd_n;
  logic       wr_n;
  logic [7:0] dIn;
  logic [7:0] dataOut;
  logic       dataOe_n;
  logic       out0;
  logic       out1;
  logic       baud;
  int         n_fail = 0;
  int         checked = 0;
  int         cyc = 0;

  interval_timer_unit interval_timer_unit_inst (
    .clk(clk), .sys_rst(sys_rst), .bufferedBusClock(bufferedBusClock),
    .localReset(localReset), .timerDecodeA_n(decA_n),
    .timerDecodeB_n(decB_n), .addrBitOne(a1), .addrBitTwo(a2),
    .readStrobe_n(rd_n), .advancedWriteStrobe_n(wr_n), .dataIn(dIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .counter0TickOut(out0),
    .counter1TimerOut(out1), .transmitBaudClock(baud));

  cpu_bus_model cpu_bus_model_inst (
    .clk(clk), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .timerDecodeA_n(decA_n), .timerDecodeB_n(decB_n), .addrBitOne(a1),
    .addrBitTwo(a2), .readStrobe_n(rd_n), .advancedWriteStrobe_n(wr_n),
    .dataIn(dIn));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // bus clock of four system clocks, close to the real ratio
  initial begin
    bufferedBusClock = 1'b0;
    forever begin
      repeat (2) @(posedge clk);
      bufferedBusClock <= ~bufferedBusClock;
    end
  end

  task automatic finish_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // low byte then high byte, both must be driven
  task automatic rd16(input logic [1:0] s, input logic [1:0] a,
                      output logic [15:0] v);
    logic oe;
    cpu_bus_model_inst.rd(s, a, v[7:0], oe);
    chk(oe, 1'b0);
    cpu_bus_model_inst.rd(s, a, v[15:8], oe);
    chk(oe, 1'b0);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk({dataOe_n, out0, out1, baud}, 16'h0009);
  endtask

  task automatic t_count0;
    logic [15:0] v1;
    logic [15:0] v2;
    cpu_bus_model_inst.wr(2'h0, 2'h3, 8'h00);
    rd16(2'h0, 2'h0, v1);
    chk(v1 <= 16'h3000 && v1 > 16'h2f00, 1'b1);
    repeat (200) @(posedge clk);
    cpu_bus_model_inst.wr(2'h1, 2'h3, 8'h00);
    rd16(2'h1, 2'h0, v2);
    chk((v1 - v2) >= 16'h6 && (v1 - v2) <= 16'h9, 1'b1);
  endtask

  // terminal count of 8 on counter 2 ends in ~64 clk at bus/2
  task automatic t_count2;
    cpu_bus_model_inst.wr(2'h0, 2'h3, 8'hb0);
    cpu_bus_model_inst.wr(2'h0, 2'h2, 8'h08);
    cpu_bus_model_inst.wr(2'h1, 2'h2, 8'h00);
    chk(baud, 1'b1);
    repeat (80) @(posedge clk);
    chk(baud, 1'b0);
  endtask

  // count of 6 on counter 1 needs at least 160 clk at bus/8
  task automatic t_count1;
    logic [15:0] v;
    cpu_bus_model_inst.wr(2'h1, 2'h3, 8'h70);
    cpu_bus_model_inst.wr(2'h1, 2'h1, 8'h06);
    cpu_bus_model_inst.wr(2'h0, 2'h1, 8'h00);
    chk(out1, 1'b0);
    repeat (95) @(posedge clk);
    rd16(2'h1, 2'h1, v);
    chk(v >= 16'h1 && v <= 16'h5, 1'b1);
    chk(out1, 1'b0);
    repeat (120) @(posedge clk);
    chk(out1, 1'b1);
  endtask

  task automatic t_refused;
    logic [7:0] d;
    logic       oe;
    cpu_bus_model_inst.rd(2'h2, 2'h0, d, oe);
    chk(oe, 1'b1);
    cpu_bus_model_inst.rd(2'h0, 2'h3, d, oe);
    chk(oe, 1'b1);
    cpu_bus_model_inst.wr(2'h2, 2'h3, 8'hb0);
    cpu_bus_model_inst.wr(2'h2, 2'h2, 8'h05);
    cpu_bus_model_inst.wr(2'h2, 2'h2, 8'h00);
    repeat (10) @(posedge clk);
    chk(baud, 1'b0);
  endtask

  task automatic t_lreset;
    localReset <= 1'b1;
    repeat (10) @(posedge clk);
    cpu_bus_model_inst.wr(2'h0, 2'h3, 8'h70);
    cpu_bus_model_inst.wr(2'h0, 2'h1, 8'h02);
    cpu_bus_model_inst.wr(2'h0, 2'h1, 8'h00);
    repeat (300) @(posedge clk);
    chk(out1, 1'b0);
    localReset <= 1'b0;
    repeat (150) @(posedge clk);
    chk(out1, 1'b1);
  endtask

  // rate mode count of 3 on counter 0 pulses once every 96 clk
  task automatic t_tick0;
    logic seen;
    seen = 1'b0;
    cpu_bus_model_inst.wr(2'h0, 2'h3, 8'h14);
    cpu_bus_model_inst.wr(2'h1, 2'h0, 8'h03);
    chk(out0, 1'b0);
    repeat (130) begin
      @(negedge clk);
      seen = seen | out0;
    end
    chk(seen, 1'b1);
  endtask

  initial begin
    sys_rst = 1'b1;
    localReset = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_count0;
    t_count2;
    t_count1;
    t_refused;
    t_lreset;
    t_tick0;
    finish_test;
  end
endmodule

`default_nettype wire
